//--- core/usm_cfg.svh
`ifndef USM_CFG_SVH
`define USM_CFG_SVH

// Special function register addresses, reset and unmapped-read values
`define USM_ADDR_CTRL      8'hF1
`define USM_ADDR_DATA      8'hF2
`define USM_CTRL_RESET     8'h00
`define USM_UNMAPPED_READ  8'h00

// Control register field positions
`define USM_BIT_FE_ML      7
`define USM_BIT_OVR_MH     6
`define USM_BIT_TCOL_MP    5
`define USM_BIT_REN        4
`define USM_BIT_TB8        3
`define USM_BIT_RB8        2
`define USM_BIT_TI         1
`define USM_BIT_RI         0

// Oversampling: sixteen baud ticks per bit time
`define USM_OVS_FIRST      4'h0
`define USM_OVS_STEP       4'h1
`define USM_OVS_MID        4'h7
`define USM_OVS_LAST       4'hF
`define USM_BIT_FIRST      3'h0
`define USM_BIT_STEP       3'h1
`define USM_BIT_LAST       3'h7

// Transmit queue
`define USM_FIFO_DEPTH     8
`define USM_DATA_W         8

// Software side: reload for a divide factor with doubler set and timer fed by the system clock
`define USM_BAUD_FACTOR    16
`define USM_T1_RELOAD(div) (8'(256 - ((div) / `USM_BAUD_FACTOR)))

`endif

//--- core/usm_fifo.sv
`timescale 1ns/1ps
module usm_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
)
(
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_valid,
	output logic                  o_ready,
	input  wire logic [WIDTH-1:0] i_data,
	output logic                  o_valid,
	input  wire logic             i_ready,
	output logic [WIDTH-1:0]      o_data
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH)
		begin : g_bad_depth
			$error("usm_fifo depth must be a power of two of at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0]      wr_ptr_ff;
	logic [AW:0]      rd_ptr_ff;
	logic             push;
	logic             pop;

	// Extra pointer bit separates full from empty
	assign o_ready = (wr_ptr_ff[AW] == rd_ptr_ff[AW]) || (wr_ptr_ff[AW-1:0] != rd_ptr_ff[AW-1:0]);
	assign o_valid = wr_ptr_ff != rd_ptr_ff;
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;
	assign o_data  = mem_ff[rd_ptr_ff[AW-1:0]];

	always_ff @(posedge i_clk)
	begin
		if (push)
			mem_ff[wr_ptr_ff[AW-1:0]] <= i_data;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end
		else
		begin
			wr_ptr_ff <= push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
			rd_ptr_ff <= pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
		end
	end
endmodule

//--- core/usm_pkg.sv
package usm_pkg;

	typedef enum logic [1:0]
	{
		USM_MODE_SYNC  = 2'b00,
		USM_MODE_ASYNC8 = 2'b01,
		USM_MODE_FIXED9 = 2'b10,
		USM_MODE_VAR9  = 2'b11
	} usm_mode_e;

	typedef enum logic [2:0]
	{
		USM_FR_IDLE  = 3'b000,
		USM_FR_START = 3'b001,
		USM_FR_DATA  = 3'b010,
		USM_FR_NINTH = 3'b011,
		USM_FR_STOP  = 3'b100
	} usm_frame_e;

	typedef struct packed
	{
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} usm_sfr_req_s;

endpackage

//--- core/usm_top.sv
`timescale 1ns/1ps
`include "usm_cfg.svh"
// Function
// R1: View select high maps error flags
// R2: View select low maps mode bits
// R3: Buffer write while sending sets collision
// R4: Collision flag sits at bit 5
// R5: New byte while unread sets overrun
// R6: Overrun flag sits at bit 6
// R7: Low stop bit sets frame error
// R8: Frame error flag sits at bit 7
// R9: Mode 00 synchronous, 01 8-bit async
// R10: Software picks reload: 16*(256-reload)=divide
// R11: Low bits REN,TB8,RB8,TI,RI; reset zero
// R12: Transmit done at stop bit start
// R13: Load buffer only when receive flag clear
// R14: Error flags clear only by software
module usm_top
	import usm_pkg::*;
#(
	parameter int FIFO_DEPTH = `USM_FIFO_DEPTH
)
(
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire usm_sfr_req_s i_sfr,
	output logic [7:0]        o_sfr_rdata,
	output logic              o_tx_ready,
	input  wire logic         i_status_view_select,
	input  wire logic         i_baud_tick,
	input  wire logic         i_rx,
	output logic              o_tx
);
	function automatic logic sfr_hit(input usm_sfr_req_s req, input logic [7:0] addr);
		sfr_hit = req.addr == addr;
	endfunction

	// Control and status state
	logic       mode_low_ff;
	logic       mode_high_ff;
	logic       mp_en_ff;
	logic       fe_ff;
	logic       ovr_ff;
	logic       tcol_ff;
	logic       ren_ff;
	logic       tb8_ff;
	logic       rb8_ff;
	logic       ti_ff;
	logic       ri_ff;
	logic [7:0] rx_buf_ff;
	logic [7:0] rdata_ff;
	logic       rx_meta_ff;
	logic       rx_sync_ff;

	// Transmitter state
	usm_frame_e tx_state_ff;
	usm_frame_e nxt_tx_state;
	logic [3:0] tx_tick_ff;
	logic [3:0] nxt_tx_tick;
	logic [2:0] tx_bit_ff;
	logic [2:0] nxt_tx_bit;
	logic [7:0] tx_shift_ff;
	logic [7:0] nxt_tx_shift;
	logic       tx_ninth_ff;
	logic       nxt_tx_ninth;
	logic       tx_pin_ff;
	logic       nxt_tx_pin;
	logic       tx_done_evt;

	// Receiver state
	usm_frame_e rx_state_ff;
	usm_frame_e nxt_rx_state;
	logic [3:0] rx_tick_ff;
	logic [3:0] nxt_rx_tick;
	logic [2:0] rx_bit_ff;
	logic [2:0] nxt_rx_bit;
	logic [7:0] rx_shift_ff;
	logic [7:0] nxt_rx_shift;
	logic       rx_ninth_ff;
	logic       nxt_rx_ninth;
	logic       rx_done;

	usm_mode_e  mode;
	logic       is_async;
	logic       is_nine;
	logic       wr_ctrl;
	logic       wr_data;
	logic       wr_status;
	logic       wr_mode;
	logic [7:0] wd;
	logic [7:0] ctrl_view;
	logic [7:0] rd_val;
	logic       fifo_valid;
	logic [7:0] fifo_data;
	logic       tx_idle;
	logic       tx_busy;
	logic       tx_bit_end;
	logic       rx_sample;
	logic       rx_accept;
	logic       rx_load;
	logic       rx_stop_val;
	logic       set_tcol;
	logic       set_ovr;
	logic       set_fe;

	assign mode     = usm_mode_e'({mode_low_ff, mode_high_ff}); // [R9]
	assign is_async = mode != USM_MODE_SYNC; // [R9]
	assign is_nine  = (mode == USM_MODE_FIXED9) || (mode == USM_MODE_VAR9);

	assign wd        = i_sfr.wdata;
	assign wr_ctrl   = i_sfr.wr && sfr_hit(i_sfr, `USM_ADDR_CTRL);
	assign wr_data   = i_sfr.wr && sfr_hit(i_sfr, `USM_ADDR_DATA);
	assign wr_status = wr_ctrl && i_status_view_select; // [R1]
	assign wr_mode   = wr_ctrl && !i_status_view_select; // [R2]

	// Upper three bits swap meaning with the view select
	assign ctrl_view = {i_status_view_select ? fe_ff : mode_low_ff, // [R8] [R1] [R2]
		i_status_view_select ? ovr_ff : mode_high_ff, // [R6]
		i_status_view_select ? tcol_ff : mp_en_ff, // [R4]
		ren_ff, tb8_ff, rb8_ff, ti_ff, ri_ff}; // [R11]
	assign rd_val = sfr_hit(i_sfr, `USM_ADDR_CTRL) ? ctrl_view :
		sfr_hit(i_sfr, `USM_ADDR_DATA) ? rx_buf_ff : `USM_UNMAPPED_READ;
	assign o_sfr_rdata = rdata_ff;
	assign o_tx        = tx_pin_ff;

	// Event flags: a hardware set in the same cycle as a software write wins
	assign tx_busy   = tx_state_ff != USM_FR_IDLE;
	assign set_tcol  = wr_data && tx_busy; // [R3]
	assign rx_stop_val = rx_sync_ff;
	assign set_fe    = rx_done && !rx_stop_val; // [R7]
	assign set_ovr   = rx_done && ri_ff; // [R5]
	assign rx_accept = is_nine ? (!mp_en_ff || rx_ninth_ff) : (!mp_en_ff || rx_stop_val);
	assign rx_load   = rx_done && !ri_ff && rx_accept; // [R13]

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rx_meta_ff <= 1'b1;
			rx_sync_ff <= 1'b1;
		end
		else
		begin
			rx_meta_ff <= i_rx;
			rx_sync_ff <= rx_meta_ff;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			{mode_low_ff, mode_high_ff, mp_en_ff, ren_ff, tb8_ff, rb8_ff, ti_ff, ri_ff} <= `USM_CTRL_RESET; // [R11]
			fe_ff     <= 1'b0;
			ovr_ff    <= 1'b0;
			tcol_ff   <= 1'b0;
			rx_buf_ff <= 8'h00;
			rdata_ff  <= 8'h00;
		end
		else
		begin
			mode_low_ff  <= wr_mode ? wd[`USM_BIT_FE_ML] : mode_low_ff; // [R2]
			mode_high_ff <= wr_mode ? wd[`USM_BIT_OVR_MH] : mode_high_ff;
			mp_en_ff     <= wr_mode ? wd[`USM_BIT_TCOL_MP] : mp_en_ff;
			fe_ff   <= (wr_status ? wd[`USM_BIT_FE_ML] : fe_ff) | set_fe; // [R14] [R8]
			ovr_ff  <= (wr_status ? wd[`USM_BIT_OVR_MH] : ovr_ff) | set_ovr; // [R14] [R6]
			tcol_ff <= (wr_status ? wd[`USM_BIT_TCOL_MP] : tcol_ff) | set_tcol; // [R14] [R4]
			ren_ff  <= wr_ctrl ? wd[`USM_BIT_REN] : ren_ff; // [R11]
			tb8_ff  <= wr_ctrl ? wd[`USM_BIT_TB8] : tb8_ff;
			rb8_ff  <= rx_load ? (is_nine ? rx_ninth_ff : rx_stop_val) :
				(wr_ctrl ? wd[`USM_BIT_RB8] : rb8_ff); // [R13]
			ti_ff   <= (wr_ctrl ? wd[`USM_BIT_TI] : ti_ff) | tx_done_evt; // [R12]
			ri_ff   <= (wr_ctrl ? wd[`USM_BIT_RI] : ri_ff) | rx_load; // [R13]
			rx_buf_ff <= rx_load ? rx_shift_ff : rx_buf_ff; // [R13]
			rdata_ff  <= i_sfr.rd ? rd_val : rdata_ff;
		end
	end

	// Transmit queue lets software post bytes ahead; a data write while it is full is dropped
	usm_fifo #(
		.WIDTH (`USM_DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_valid (wr_data),
		.o_ready (o_tx_ready),
		.i_data  (wd),
		.o_valid (fifo_valid),
		.i_ready (tx_idle),
		.o_data  (fifo_data)
	);

	assign tx_idle    = tx_state_ff == USM_FR_IDLE;
	assign tx_bit_end = i_baud_tick && (tx_tick_ff == `USM_OVS_LAST);

	always_comb
	begin
		nxt_tx_state = tx_state_ff;
		nxt_tx_tick  = (tx_busy && i_baud_tick) ? tx_tick_ff + `USM_OVS_STEP : tx_tick_ff;
		nxt_tx_bit   = tx_bit_ff;
		nxt_tx_shift = tx_shift_ff;
		nxt_tx_ninth = tx_ninth_ff;
		nxt_tx_pin   = tx_pin_ff;
		tx_done_evt  = 1'b0;
		case (tx_state_ff)
			USM_FR_IDLE:
			begin
				nxt_tx_pin  = 1'b1;
				nxt_tx_tick = `USM_OVS_FIRST;
				if (fifo_valid)
				begin
					nxt_tx_shift = fifo_data;
					nxt_tx_ninth = tb8_ff;
					nxt_tx_bit   = `USM_BIT_FIRST;
					nxt_tx_state = is_async ? USM_FR_START : USM_FR_DATA;
					nxt_tx_pin   = is_async ? 1'b0 : fifo_data[0];
				end
			end
			USM_FR_START:
			begin
				if (tx_bit_end)
				begin
					nxt_tx_state = USM_FR_DATA;
					nxt_tx_pin   = tx_shift_ff[0];
				end
			end
			USM_FR_DATA:
			begin
				if (tx_bit_end)
				begin
					if (tx_bit_ff != `USM_BIT_LAST)
					begin
						nxt_tx_bit   = tx_bit_ff + `USM_BIT_STEP;
						nxt_tx_shift = {1'b0, tx_shift_ff[7:1]};
						nxt_tx_pin   = tx_shift_ff[1];
					end
					else if (is_async && is_nine)
					begin
						nxt_tx_state = USM_FR_NINTH;
						nxt_tx_pin   = tx_ninth_ff;
					end
					else
					begin
						// Stop bit starts here; synchronous mode ends after the eighth bit
						nxt_tx_state = is_async ? USM_FR_STOP : USM_FR_IDLE;
						nxt_tx_pin   = 1'b1;
						tx_done_evt  = 1'b1; // [R12]
					end
				end
			end
			USM_FR_NINTH:
			begin
				if (tx_bit_end)
				begin
					nxt_tx_state = USM_FR_STOP;
					nxt_tx_pin   = 1'b1;
					tx_done_evt  = 1'b1; // [R12]
				end
			end
			USM_FR_STOP:
			begin
				if (tx_bit_end)
					nxt_tx_state = USM_FR_IDLE;
			end
			default:
			begin
				nxt_tx_state = USM_FR_IDLE;
				nxt_tx_pin   = 1'b1;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			tx_state_ff <= USM_FR_IDLE;
			tx_tick_ff  <= `USM_OVS_FIRST;
			tx_bit_ff   <= `USM_BIT_FIRST;
			tx_shift_ff <= 8'h00;
			tx_ninth_ff <= 1'b0;
			tx_pin_ff   <= 1'b1;
		end
		else
		begin
			tx_state_ff <= nxt_tx_state;
			tx_tick_ff  <= nxt_tx_tick;
			tx_bit_ff   <= nxt_tx_bit;
			tx_shift_ff <= nxt_tx_shift;
			tx_ninth_ff <= nxt_tx_ninth;
			tx_pin_ff   <= nxt_tx_pin;
		end
	end

	// Receiver samples mid-bit: half a bit after the start edge, then every bit time
	assign rx_sample = i_baud_tick && (rx_tick_ff == `USM_OVS_LAST);

	always_comb
	begin
		nxt_rx_state = rx_state_ff;
		nxt_rx_tick  = i_baud_tick ? rx_tick_ff + `USM_OVS_STEP : rx_tick_ff;
		nxt_rx_bit   = rx_bit_ff;
		nxt_rx_shift = rx_shift_ff;
		nxt_rx_ninth = rx_ninth_ff;
		rx_done      = 1'b0;
		case (rx_state_ff)
			USM_FR_IDLE:
			begin
				nxt_rx_tick = `USM_OVS_FIRST;
				nxt_rx_bit  = `USM_BIT_FIRST;
				if (ren_ff && is_async && !rx_sync_ff)
					nxt_rx_state = USM_FR_START;
			end
			USM_FR_START:
			begin
				if (i_baud_tick && rx_tick_ff == `USM_OVS_MID)
				begin
					// A start bit gone high by mid-bit is a glitch
					nxt_rx_tick  = `USM_OVS_FIRST;
					nxt_rx_state = rx_sync_ff ? USM_FR_IDLE : USM_FR_DATA;
				end
			end
			USM_FR_DATA:
			begin
				if (rx_sample)
				begin
					nxt_rx_shift = {rx_sync_ff, rx_shift_ff[7:1]};
					nxt_rx_bit   = rx_bit_ff + `USM_BIT_STEP;
					if (rx_bit_ff == `USM_BIT_LAST)
						nxt_rx_state = is_nine ? USM_FR_NINTH : USM_FR_STOP;
				end
			end
			USM_FR_NINTH:
			begin
				if (rx_sample)
				begin
					nxt_rx_ninth = rx_sync_ff;
					nxt_rx_state = USM_FR_STOP;
				end
			end
			USM_FR_STOP:
			begin
				if (rx_sample)
				begin
					rx_done      = 1'b1; // [R5] [R7] [R13]
					nxt_rx_state = USM_FR_IDLE;
				end
			end
			default:
			begin
				nxt_rx_state = USM_FR_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rx_state_ff <= USM_FR_IDLE;
			rx_tick_ff  <= `USM_OVS_FIRST;
			rx_bit_ff   <= `USM_BIT_FIRST;
			rx_shift_ff <= 8'h00;
			rx_ninth_ff <= 1'b0;
		end
		else
		begin
			rx_state_ff <= nxt_rx_state;
			rx_tick_ff  <= nxt_rx_tick;
			rx_bit_ff   <= nxt_rx_bit;
			rx_shift_ff <= nxt_rx_shift;
			rx_ninth_ff <= nxt_rx_ninth;
		end
	end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
`include "usm_cfg.svh"
module tb_top
	import usm_pkg::*;
;
	localparam logic [7:0] C = 8'hF1;
	localparam logic [7:0] D = 8'hF2;
	logic         clk;
	logic         rst_n;
	usm_sfr_req_s sfr;
	logic [7:0]   rdata;
	logic         tx_rdy;
	logic         view;
	logic         tick;
	logic [1:0]   tcnt;
	logic         rx_line;
	logic         tx_line;
	logic [7:0]   q;
	logic [7:0]   rb;
	logic         sb;
	int           num_errors;
	int           check_count;
	usm_top DUT
	(
		.i_clk                (clk),
		.i_rst_n              (rst_n),
		.i_sfr                (sfr),
		.o_sfr_rdata          (rdata),
		.o_tx_ready           (tx_rdy),
		.i_status_view_select (view),
		.i_baud_tick          (tick),
		.i_rx                 (rx_line),
		.o_tx                 (tx_line)
	);
	usm_peer u_peer
	(
		.i_clk  (clk),
		.i_tick (tick),
		.i_line (tx_line),
		.o_line (rx_line)
	);
	always #5 clk = ~clk;
	// Fast ticks stand in for the timer reload overflow to keep frames short
	always @(posedge clk)
	begin
		tcnt <= tcnt + 2'h1;
		tick <= (tcnt == 2'h3);
	end
	task automatic chk8(input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic chk1(input logic e, input logic g);
		check_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic wr(input logic v, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		view <= v;
		sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		sfr <= '0;
	endtask
	task automatic rd(input logic v, input logic [7:0] a, output logic [7:0] r);
		@(posedge clk);
		view <= v;
		sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		sfr <= '0;
		#1;
		r = rdata;
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (30000) @(posedge clk);
		num_errors++;
		final_report();
	end
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		sfr = '0;
		view = 1'b0;
		tick = 1'b0;
		tcnt = 2'h0;
		num_errors = 0;
		check_count = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd(1'b0, C, q);
		chk8(8'h00, q);
		wr(1'b0, 8'h33, 8'hFF);
		rd(1'b0, 8'h33, q);
		chk8(8'h00, q);
		rd(1'b1, C, q);
		chk8(8'h00, q);
		chk8(8'hF4, `USM_T1_RELOAD(192));
		$display("test reset done");
		for (int m = 0; m < 4; m++)
		begin
			wr(1'b0, C, {m[1:0], 6'h10});
			rd(1'b0, C, q);
			chk8({m[1:0], 6'h10}, q);
		end
		wr(1'b0, C, 8'h50);
		rd(1'b1, C, q);
		chk8(8'h10, q);
		wr(1'b1, C, 8'hF0);
		rd(1'b1, C, q);
		chk8(8'hF0, q);
		rd(1'b0, C, q);
		chk8(8'h50, q);
		wr(1'b1, C, 8'h10);
		rd(1'b1, C, q);
		chk8(8'h10, q);
		$display("test view done");
		fork
			u_peer.recv(rb, sb);
			begin
				wr(1'b0, D, 8'hA5);
				repeat (20) @(posedge clk);
				wr(1'b0, D, 8'h5A);
			end
		join
		chk8(8'hA5, rb);
		chk1(1'b1, sb);
		rd(1'b1, C, q);
		chk8(8'h32, q);
		u_peer.recv(rb, sb);
		chk8(8'h5A, rb);
		// Synchronous mode: eight bits, no framing, done flag after the last one
		wr(1'b0, C, 8'h00);
		wr(1'b0, D, 8'h00);
		repeat (600) @(posedge clk);
		rd(1'b0, C, q);
		chk8(8'h02, q);
		wr(1'b0, C, 8'h50);
		wr(1'b1, C, 8'h10);
		$display("test transmit done");
		u_peer.send(8'h3C, 1'b1);
		repeat (10) @(posedge clk);
		rd(1'b1, C, q);
		chk8(8'h15, q);
		rd(1'b0, D, q);
		chk8(8'h3C, q);
		u_peer.send(8'h77, 1'b1);
		repeat (10) @(posedge clk);
		rd(1'b1, C, q);
		chk8(8'h55, q);
		rd(1'b0, D, q);
		chk8(8'h3C, q);
		wr(1'b1, C, 8'h10);
		u_peer.send(8'h81, 1'b0);
		repeat (10) @(posedge clk);
		rd(1'b1, C, q);
		chk8(8'h91, q);
		rd(1'b0, D, q);
		chk8(8'h81, q);
		$display("test receive done");
		// Reset in mid-run must bring the status view and the data buffer back to zero
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd(1'b1, C, q);
		chk8(8'h00, q);
		rd(1'b0, D, q);
		chk8(8'h00, q);
		$display("test reset again done");
		final_report();
	end
endmodule

//--- dv/usm_peer.sv
`timescale 1ns/1ps
module usm_peer
(
	input  wire logic i_clk,
	input  wire logic i_tick,
	input  wire logic i_line,
	output logic      o_line
);
	// Idle line rests high between frames
	initial o_line = 1'b1;
	task automatic ticks(input int n);
		int k;
		k = 0;
		while (k < n)
		begin
			@(posedge i_clk);
			if (i_tick)
				k++;
		end
	endtask
	task automatic send(input logic [7:0] d, input logic stop);
		ticks(1);
		o_line <= 1'b0;
		ticks(16);
		for (int i = 0; i < 8; i++)
		begin
			o_line <= d[i];
			ticks(16);
		end
		o_line <= stop;
		ticks(16);
		o_line <= 1'b1;
	endtask
	// Samples mid-bit, so a drifting bit edge still reads right
	task automatic recv(output logic [7:0] d, output logic stop);
		while (i_line !== 1'b0)
			@(posedge i_clk);
		ticks(8);
		for (int i = 0; i < 8; i++)
		begin
			ticks(16);
			d[i] = i_line;
		end
		ticks(16);
		stop = i_line;
	endtask
endmodule

//--- dv/usm_top_props.sv
`timescale 1ns/1ps
`include "usm_cfg.svh"
module usm_top_props
	import usm_pkg::*;
(
	input wire logic         i_clk,
	input wire logic         i_rst_n,
	input wire usm_sfr_req_s i_sfr,
	input wire logic [7:0]   o_sfr_rdata,
	input wire logic         o_tx_ready,
	input wire logic         i_status_view_select,
	input wire logic         i_baud_tick,
	input wire logic         i_rx,
	input wire logic         o_tx
);
	logic [2:0] seen_ff;
	logic       rd1_ff;
	logic       tcol_ff;
	wire        wr_c = i_sfr.wr && i_sfr.addr == `USM_ADDR_CTRL;
	wire        wr_d = i_sfr.wr && i_sfr.addr == `USM_ADDR_DATA;
	wire        rd_c = i_sfr.rd && !i_sfr.wr && i_sfr.addr == `USM_ADDR_CTRL;
	wire        rd_x = i_sfr.rd && i_sfr.addr != `USM_ADDR_CTRL && i_sfr.addr != `USM_ADDR_DATA;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	// Any control write may clear flags, so forget what was seen
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			seen_ff <= 3'h0;
			rd1_ff  <= 1'b0;
			tcol_ff <= 1'b0;
		end
		else
		begin
			rd1_ff  <= rd_c && i_status_view_select;
			seen_ff <= wr_c ? 3'h0 : (rd1_ff ? (seen_ff | o_sfr_rdata[7:5]) : seen_ff);
			tcol_ff <= wr_c ? 1'b0 : (tcol_ff || (wr_d && !o_tx));
		end
	end
	sequence s_wr(v);
		wr_c && i_status_view_select == v;
	endsequence
	sequence s_rd(v);
		rd_c && i_status_view_select == v;
	endsequence
	sequence s_wr_rd(v);
		s_wr(v) ##1 !i_sfr.wr ##1 s_rd(v);
	endsequence
	property p_reset;
		$rose(i_rst_n) |-> o_tx && o_tx_ready && o_sfr_rdata == 8'h00;
	endproperty
	property p_mode;
		s_wr_rd(1'b0) |=> (o_sfr_rdata & 8'hE0) == ($past(i_sfr.wdata, 3) & 8'hE0);
	endproperty
	property p_low;
		(wr_c ##1 !i_sfr.wr ##1 rd_c) |=> (o_sfr_rdata & 8'h18) == ($past(i_sfr.wdata, 3) & 8'h18);
	endproperty
	property p_err;
		s_wr_rd(1'b1) |=> (o_sfr_rdata & $past(i_sfr.wdata, 3) & 8'hE0) == ($past(i_sfr.wdata, 3) & 8'hE0);
	endproperty
	property p_sticky;
		rd1_ff |-> (o_sfr_rdata[7:5] & seen_ff) == seen_ff;
	endproperty
	property p_tcol;
		rd1_ff && tcol_ff |-> o_sfr_rdata[5];
	endproperty
	property p_unmap;
		rd_x |=> o_sfr_rdata == 8'h00;
	endproperty
	property p_hold;
		!i_sfr.rd |=> $stable(o_sfr_rdata);
	endproperty
	a_reset: assert property (p_reset) else $error("outputs not idle after reset");
	a_mode: assert property (p_mode) else $error("mode bits not kept");
	a_low: assert property (p_low) else $error("low control bits not kept");
	a_err: assert property (p_err) else $error("error flag write lost");
	a_sticky: assert property (p_sticky) else $error("error flag dropped");
	a_tcol: assert property (p_tcol) else $error("collision not flagged");
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind usm_top usm_top_props u_props
(
	.i_clk                (i_clk),
	.i_rst_n              (i_rst_n),
	.i_sfr                (i_sfr),
	.o_sfr_rdata          (o_sfr_rdata),
	.o_tx_ready           (o_tx_ready),
	.i_status_view_select (i_status_view_select),
	.i_baud_tick          (i_baud_tick),
	.i_rx                 (i_rx),
	.o_tx                 (o_tx)
);
